/* igd_defines.vh */
`ifndef IGD_DEFINES_VH
`define IGD_DEFINES_VH

// Parallel word widths for the two gearing ratios
`define IGD_X1_WIDTH 2
`define IGD_X2_WIDTH 4
`define IGD_WORD_WIDTH 4

// Gearing mode select codes
`define IGD_MODE_X1 1'b0
`define IGD_MODE_X2 1'b1

// Reset values and the last x2 counter value
`define IGD_WORD_RESET 4'h0
`define IGD_PAIR_RESET 2'h0
`define IGD_BIT_RESET 1'b0
`define IGD_CNT_RESET 2'h0
`define IGD_CNT_LAST 2'h3

// Synchroniser depth for pin inputs
`define IGD_SYNC_STAGES 2

// Synchroniser pin count and bit positions
`define IGD_PIN_COUNT 4
`define IGD_PIN_DATA 0
`define IGD_PIN_ECL 1
`define IGD_PIN_SCL 2
`define IGD_PIN_MODE 3

`endif

/* igd_deserializer.v */
// Function
// - Bit zero of every parallel word holds the earliest serial bit received.
// - In x1 mode the serial stream becomes two-bit words.
// - The x1 path runs from the core system clock with no domain crossing.
// - In x1 mode the first stage samples data on both system clock edges.
// - In x1 mode a second stage presents the two captured bits together.
// - In x2 mode the serial stream becomes four-bit words.
// - In x2 mode capture uses the fast edge clock, delivery the system clock.
// - In x2 mode the first stage samples data on both fast edge clock edges.
// - In x2 mode a second stage holds the assembled word in the fast domain.
// - In x2 mode a third stage moves the held word into the system domain.
`timescale 1ns/1ps
`default_nettype none
`include "igd_defines.vh"

module igd_deserializer (
  input wire clk,
  input wire nrst,
  input wire gear_x2_mode,
  input wire fast_edge_clock,
  input wire link_sys_clock,
  input wire serial_data,
  input wire out_ready,
  output reg [`IGD_WORD_WIDTH-1:0] out_data_reg,
  output reg out_valid_reg,
  output reg out_x2_word_reg,
  output reg in_ready_reg,
  output reg overflow_reg
);

  // Pin order in the synchroniser: data, edge clock, system clock, mode
  wire [`IGD_PIN_COUNT-1:0] pin_raw;
  wire [`IGD_PIN_COUNT-1:0] pin_sync;
  reg ecl_prev_reg;
  reg scl_prev_reg;
  wire data_s;
  wire ecl_s;
  wire scl_s;
  wire mode_s;

  // Placement follows the pin index macros
  assign pin_raw[`IGD_PIN_DATA] = serial_data;
  assign pin_raw[`IGD_PIN_ECL] = fast_edge_clock;
  assign pin_raw[`IGD_PIN_SCL] = link_sys_clock;
  assign pin_raw[`IGD_PIN_MODE] = gear_x2_mode;

  // Two flip-flops per pin; only the second is read by any logic
  genvar g;
  generate
    for (g = 0; g < `IGD_PIN_COUNT; g = g + 1)
    begin : g_sync
      reg first_reg;
      reg second_reg;
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          first_reg <= `IGD_BIT_RESET;
          second_reg <= `IGD_BIT_RESET;
        end
        else
        begin
          first_reg <= pin_raw[g];
          second_reg <= first_reg;
        end
      end
      assign pin_sync[g] = second_reg;
    end
  endgenerate

  assign data_s = pin_sync[`IGD_PIN_DATA];
  assign ecl_s = pin_sync[`IGD_PIN_ECL];
  assign scl_s = pin_sync[`IGD_PIN_SCL];
  assign mode_s = pin_sync[`IGD_PIN_MODE];

  // Clock levels one cycle back; reset to the idle low level of both
  // link clocks so that no false edge follows reset
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ecl_prev_reg <= `IGD_BIT_RESET;
      scl_prev_reg <= `IGD_BIT_RESET;
    end
    else
    begin
      ecl_prev_reg <= ecl_s;
      scl_prev_reg <= scl_s;
    end
  end

  // Mode decode shared by every stage that gates on the gearing ratio
  function igd_is_x2;
    input mode_bit;
    begin
      igd_is_x2 = (mode_bit == `IGD_MODE_X2);
    end
  endfunction

  // Edge strobes; data shares the clock's sync delay so timing holds
  wire ecl_rise = ecl_s & ~ecl_prev_reg;
  wire ecl_fall = ~ecl_s & ecl_prev_reg;
  wire scl_rise = scl_s & ~scl_prev_reg;
  wire scl_fall = ~scl_s & scl_prev_reg;

  // x1 path: first stage catches one bit on each system clock edge
  // A pair only counts once a falling edge is seen since mode entry,
  // so a stale bit from before a mode change never forms a word
  reg x1_rise_bit_reg;
  reg x1_fall_bit_reg;
  reg x1_have_reg;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      x1_rise_bit_reg <= `IGD_BIT_RESET;
      x1_fall_bit_reg <= `IGD_BIT_RESET;
      x1_have_reg <= 1'b0;
    end
    else if (!igd_is_x2(mode_s))
    begin
      if (scl_rise)
        x1_rise_bit_reg <= data_s;
      if (scl_fall)
      begin
        x1_fall_bit_reg <= data_s;
        x1_have_reg <= 1'b1;
      end
    end
    else
      x1_have_reg <= 1'b0;
  end

  // x1 second stage: pair presented at the next rising edge
  // The last pair of a burst waits for a rising edge that may never
  // come; leaving x1 mode discards it
  reg [`IGD_X1_WIDTH-1:0] x1_word_reg;
  reg x1_push_reg;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      x1_word_reg <= `IGD_PAIR_RESET;
      x1_push_reg <= 1'b0;
    end
    else
    begin
      x1_push_reg <= 1'b0;
      if (!igd_is_x2(mode_s) && scl_rise && x1_have_reg)
      begin
        // Rising-edge bit came first, so it lands in bit zero
        x1_word_reg <= {x1_fall_bit_reg, x1_rise_bit_reg};
        x1_push_reg <= 1'b1;
      end
    end
  end

  // x2 first stage: shift in on both fast edge clock edges
  // Word boundaries count from the first edge after entering x2; a
  // missed edge misaligns every later word until the mode is left
  reg [`IGD_X2_WIDTH-1:0] x2_shift_reg;
  reg [1:0] x2_cnt_reg;
  reg [`IGD_X2_WIDTH-1:0] x2_hold_reg;
  reg x2_hold_new_reg;
  wire ecl_edge = ecl_rise | ecl_fall;
  wire [`IGD_X2_WIDTH-1:0] x2_shift_next =
    {data_s, x2_shift_reg[`IGD_X2_WIDTH-1:1]};
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      x2_shift_reg <= `IGD_WORD_RESET;
      x2_cnt_reg <= `IGD_CNT_RESET;
      x2_hold_reg <= `IGD_WORD_RESET;
      x2_hold_new_reg <= 1'b0;
    end
    else if (igd_is_x2(mode_s))
    begin
      if (ecl_edge)
      begin
        // Newest bit enters at the top, earliest drifts to bit zero
        x2_shift_reg <= x2_shift_next;
        x2_cnt_reg <= x2_cnt_reg + 2'h1;
        if (x2_cnt_reg == `IGD_CNT_LAST)
        begin
          // Second stage holds the word stable for the crossing
          x2_hold_reg <= x2_shift_next;
          x2_hold_new_reg <= 1'b1;
        end
      end
      // Flag drops once taken, unless a new word lands in that cycle
      if (scl_rise && x2_hold_new_reg &&
          !(ecl_edge && x2_cnt_reg == `IGD_CNT_LAST))
        x2_hold_new_reg <= 1'b0;
    end
    else
    begin
      x2_cnt_reg <= `IGD_CNT_RESET;
      x2_hold_new_reg <= 1'b0;
    end
  end

  // x2 third stage: system clock edge takes the held word
  // One word per system clock rise, so that clock must not run slower
  // than every fourth edge of the fast edge clock
  reg [`IGD_X2_WIDTH-1:0] x2_word_reg;
  reg x2_push_reg;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      x2_word_reg <= `IGD_WORD_RESET;
      x2_push_reg <= 1'b0;
    end
    else
    begin
      x2_push_reg <= 1'b0;
      // Relies on the outside clocks being half rate and phase locked
      if (igd_is_x2(mode_s) && scl_rise && x2_hold_new_reg)
      begin
        x2_word_reg <= x2_hold_reg;
        x2_push_reg <= 1'b1;
      end
    end
  end

  // Select the word of the active mode; x1 words zero-extended
  // Only one path pushes in a cycle since the mode enables just one
  wire push = x1_push_reg | x2_push_reg;
  wire push_x2 = x2_push_reg;
  wire [`IGD_WORD_WIDTH-1:0] push_data = x2_push_reg ? x2_word_reg :
    {2'h0, x1_word_reg};

  // Two-entry buffer: head is the output, skid absorbs one stall
  // The receiver sees valid and data straight from flip-flops; the
  // skid entry lets a stall pass without losing a word
  reg [`IGD_WORD_WIDTH-1:0] skid_data_reg;
  reg skid_x2_reg;
  reg skid_valid_reg;
  // Head is free when empty or taken in this cycle
  wire head_free = ~out_valid_reg | out_ready;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_data_reg <= `IGD_WORD_RESET;
      out_valid_reg <= 1'b0;
      out_x2_word_reg <= 1'b0;
      skid_data_reg <= `IGD_WORD_RESET;
      skid_x2_reg <= 1'b0;
      skid_valid_reg <= 1'b0;
      in_ready_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end
    else
    begin
      in_ready_reg <= 1'b1;
      overflow_reg <= 1'b0;
      if (head_free)
      begin
        if (skid_valid_reg)
        begin
          out_data_reg <= skid_data_reg;
          out_x2_word_reg <= skid_x2_reg;
          out_valid_reg <= 1'b1;
          skid_valid_reg <= push;
          if (push)
          begin
            skid_data_reg <= push_data;
            skid_x2_reg <= push_x2;
          end
        end
        else if (push)
        begin
          out_data_reg <= push_data;
          out_x2_word_reg <= push_x2;
          out_valid_reg <= 1'b1;
        end
        else
          out_valid_reg <= 1'b0;
      end
      else if (push)
      begin
        // The link cannot be stalled, so a third word is lost
        if (skid_valid_reg)
          overflow_reg <= 1'b1;
        else
        begin
          skid_data_reg <= push_data;
          skid_x2_reg <= push_x2;
          skid_valid_reg <= 1'b1;
        end
      end
      // Warn the receiver once no further word fits
      if (!head_free && (skid_valid_reg || push))
        in_ready_reg <= 1'b0;
    end
  end

endmodule // igd_deserializer

`default_nettype wire

/* igd_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module igd_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic fast_edge_clock,
  input wire logic link_sys_clock,
  input wire logic out_ready,
  input wire logic [3:0] out_data_reg,
  input wire logic out_valid_reg,
  input wire logic out_x2_word_reg,
  input wire logic in_ready_reg,
  input wire logic overflow_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Eight edge-free cycles outlast the whole capture pipeline
  sequence quiet8;
    ($stable(link_sys_clock) && $stable(fast_edge_clock))[*8];
  endsequence
  chk_reset_clear: assert property (disable iff (1'b0) !nrst |->
    !out_valid_reg && out_data_reg == 4'h0 && !in_ready_reg)
    else $error("outputs not clear in reset");
  chk_x1_upper: assert property (out_valid_reg && !out_x2_word_reg |->
    out_data_reg[3:2] == 2'h0) else $error("x1 word upper bits set");
  chk_word_holds: assert property (out_valid_reg && !out_ready |=>
    out_valid_reg && $stable(out_data_reg) && $stable(out_x2_word_reg))
    else $error("word changed while stalled");
  chk_drop_only: assert property ($fell(out_valid_reg) |->
    $past(out_ready)) else $error("word vanished untaken");
  chk_ovf_pulse: assert property (overflow_reg |=> !overflow_reg)
    else $error("overflow longer than a cycle");
  chk_ovf_full: assert property (overflow_reg |->
    !$past(in_ready_reg)) else $error("overflow with room left");
  chk_ready_start: assert property (nrst && !$past(nrst) |->
    ##[0:1] in_ready_reg) else $error("not ready after reset");
  chk_idle_quiet: assert property (quiet8 ##0 !out_valid_reg |=>
    !out_valid_reg) else $error("word without link edge");
endmodule // igd_checker
bind igd_deserializer igd_checker igd_checker_i (.clk, .nrst,
  .fast_edge_clock, .link_sys_clock, .out_ready, .out_data_reg,
  .out_valid_reg, .out_x2_word_reg, .in_ready_reg, .overflow_reg);
`default_nettype wire

/* igd_link_src.sv */
`timescale 1ns/1ps
`default_nettype none
module igd_link_src (
  output logic fast_edge_clock,
  output logic link_sys_clock,
  output logic serial_data
);
  initial
  begin
    fast_edge_clock = 0;
    link_sys_clock = 0;
    serial_data = 0;
  end
  // Data settles half a bit before its edge; clocks idle low after
  task automatic frame(input bit x2, input int n, input logic [63:0] b);
    for (int j = 0; j < n; j++)
    begin
      serial_data <= b[j];
      #50;
      if (x2) fast_edge_clock <= ~fast_edge_clock;
      if (!x2 || j % 2 == 0) link_sys_clock <= ~link_sys_clock;
      #50;
    end
    serial_data <= ~b[n-1]; // Released line shows no stale bit
  endtask
endmodule // igd_link_src
`default_nettype wire

/* tb_igd_deserializer.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_igd_deserializer;
  logic clk, nrst, gear_x2_mode, out_ready, stall;
  wire fast_edge_clock, link_sys_clock, serial_data;
  wire [3:0] out_data_reg;
  wire out_valid_reg, out_x2_word_reg, in_ready_reg, overflow_reg;
  int fail_count = 0, n_tests = 0, seed = 44, ovf_count = 0;
  logic [4:0] expq[$];
  igd_deserializer igd_deserializer_i (.clk(clk), .nrst(nrst),
    .gear_x2_mode(gear_x2_mode), .fast_edge_clock(fast_edge_clock),
    .link_sys_clock(link_sys_clock), .serial_data(serial_data),
    .out_ready(out_ready), .out_data_reg(out_data_reg),
    .out_valid_reg(out_valid_reg), .out_x2_word_reg(out_x2_word_reg),
    .in_ready_reg(in_ready_reg), .overflow_reg(overflow_reg));
  igd_link_src igd_link_src_i (.fast_edge_clock(fast_edge_clock),
    .link_sys_clock(link_sys_clock), .serial_data(serial_data));
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // Random receiver stalls; the stall flag holds ready low to fill both buffer entries
  always @(posedge clk)
  begin
    out_ready <= (stall || nrst !== 1'b1) ? 1'b0 : 1'($random(seed));
    if (overflow_reg === 1'b1) ovf_count <= ovf_count + 1;
    if (nrst === 1'b1 && out_valid_reg === 1'b1 && out_ready === 1'b1)
      chk("word", expq.size() ? expq.pop_front() : 5'hx,
        {out_x2_word_reg, out_data_reg});
  end
  task automatic chk(string what, logic [4:0] e, logic [4:0] s);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, e, s);
    end
  endtask
  // Tag bit on top; earliest bit lands in bit zero
  function automatic logic [4:0] exp_word(bit x2, logic [63:0] b, int k);
    return x2 ? {1'b1, b[4*k+:4]} : {3'h0, b[2*k+:2]};
  endfunction
  // The extra pair or x2 word after the last word is cut off by the next mode change
  task automatic run(bit x2, int k, bit st);
    logic [63:0] b;
    int ovf_base;
    b = k == 1 ? 64'h1 : {$random(seed), $random(seed)};
    ovf_base = ovf_count;
    gear_x2_mode <= x2;
    stall <= st;
    repeat (8) @(posedge clk);
    for (int i = 0; i < (st ? 2 : k); i++) expq.push_back(exp_word(x2, b, i));
    igd_link_src_i.frame(x2, x2 ? 4*k+4 : 2*k+2, b);
    repeat (10) @(posedge clk);
    chk("refused", {4'h0, !st}, {4'h0, in_ready_reg});
    chk("overflow", {4'h0, st}, 5'(ovf_count - ovf_base));
    stall <= 1'b0;
    repeat (30) @(posedge clk);
    chk("drained", 5'h0, 5'(expq.size()));
    $display("test x2=%0d words=%0d done", x2, k);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    nrst = 1'b1;
    gear_x2_mode = 0;
    stall = 0;
    // Clean falling edge so the reset acts before the first clock
    #1 nrst = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 12; i++)
      run(i % 2, i < 2 ? 1 : i == 2 ? 3 : ($random(seed) & 7) + 1, i == 2);
    close_out();
  end
  // Watchdog well beyond the longest expected run
  initial
  begin
    #500000;
    fail_count++;
    close_out();
  end
endmodule // tb_igd_deserializer
`default_nettype wire
